// ---- core/fel_pkg.sv ----
/*
 * Constants and types of the fault escalation block.
 * Assumes one clock and a word-wide Avalon-MM port.
 */
package fel_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATE     = 8'h04;
    localparam logic [7:0] OFS_UF_STAT   = 8'h08;
    localparam logic [7:0] OFS_MP_S_STAT = 8'h0C;
    localparam logic [7:0] OFS_MP_N_STAT = 8'h10;
    localparam logic [7:0] OFS_BE_STAT   = 8'h14;
    localparam logic [7:0] OFS_SV_STAT   = 8'h18;
    localparam logic [7:0] OFS_UE_S_STAT = 8'h1C;
    localparam logic [7:0] OFS_UE_N_STAT = 8'h20;
    localparam logic [7:0] OFS_CAP0      = 8'h24;
    localparam logic [7:0] OFS_CAP1      = 8'h28;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          CTRL_BANK    = 0;
    localparam int          CTRL_SPLIT   = 1;
    localparam int          CTRL_SMASK   = 2;
    localparam int          CTRL_NMASK   = 3;
    localparam int          ST_LOCK      = 0;
    localparam int          ST_NMIBLK    = 1;
    localparam int          UF_ESC       = 1;
    localparam int          UF_LOCKUP    = 2;
    localparam int          FS_SEEN      = 0;
    localparam int          FS_VALID     = 7;
    localparam int          SV_VALID     = 6;
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Priority levels, signed, lower value wins
    // ----------------------------------------------------------------
    localparam int PRIO_W = 10;
    typedef logic signed [PRIO_W-1:0] fel_prio_t;
    localparam fel_prio_t PRIO_RESET = -10'sd4;
    localparam fel_prio_t PRIO_SHF   = -10'sd3;
    localparam fel_prio_t PRIO_NMI   = -10'sd2;
    localparam fel_prio_t PRIO_HF    = -10'sd1;
    localparam fel_prio_t PRIO_ZERO  = 10'sd0;
    localparam fel_prio_t PRIO_HALF  = 10'sd128;
    localparam fel_prio_t PRIO_IDLE  = 10'sd256;

    // ----------------------------------------------------------------
    // Fault kinds and carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FK_MEMPROT,
        FK_BUSERR,
        FK_USAGE,
        FK_SECVIOL
    } fel_kind_t;

    typedef struct packed {
        logic        valid;
        fel_kind_t   kind;
        logic        secure;
        logic [7:0]  prio;
        logic        enabled;
        logic        stack_entry;
        logic        addr_ok;
        logic [31:0] addr;
    } fel_fault_t;

    typedef struct packed {
        logic        in_handler;
        fel_kind_t   kind;
        logic        in_nmi;
        fel_prio_t   prio;
    } fel_exec_t;

    typedef struct packed {
        logic        take;
        logic        escalate;
        logic        secure_hf;
        logic        lock;
        fel_prio_t   prio;
    } fel_entry_t;

endpackage

// ---- core/fel_fault_escalation_lockup.sv ----
/*
 * Escalation to the unrecoverable fault,
 * fault address capture and lockup.
 * Assumes one fault per cycle with its
 * execution context; exception entry
 * acts on o_entry in the same cycle.
 */
// Summary of operation
// - Same-kind fault in its handler escalates
// - Fault not above serviced fault escalates
// - Fault not above execution priority escalates
// - Fault with disabled handler escalates
// - Bus fault on bus handler push proceeds
// - Bank bit 0: faults secure, -1, -2
// - Bank bit 1: nonsecure, secure fault -3
// - Secure banking: nonsecure mask blocks programmable only
// - Nonsecure priorities map to lower half when split
// - Nonsecure mask at bank bit 0 floors to 0x0 or 0x80
// - Secure mask boosts -1 or -3; nonsecure -1 at bank bit 1
// - Secure unrecoverable fault preemption by bank bit
// - Capture faulting address for address-bearing faults
// - Two capture registers split by security state
// - One shared capture register without security
// - Capture only while valid bit clear
// - Unserviceable, unescalatable fault enters lockup
// - Lockup leaves on reset, preemption, debug halt
// - Nonmaskable interrupt cannot release certain lockups
// - Memprot, usage status and address per state
// - Escalation sets the escalation indicator
`timescale 1ns/10ps
module fel_fault_escalation_lockup #(
    parameter int HAS_SEC = 1
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire logic [7:0]          i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [31:0]         i_avs_writedata,
    input  wire logic [3:0]          i_avs_byteenable,
    output logic [31:0]              o_avs_readdata,
    output logic                     o_avs_waitrequest,
    input  wire fel_pkg::fel_fault_t i_fault,
    input  wire fel_pkg::fel_exec_t  i_exec,
    input  wire logic                i_exc_req,
    input  wire logic                i_exc_is_nmi,
    input  wire fel_pkg::fel_prio_t  i_exc_prio,
    input  wire logic                i_debug_halt,
    output fel_pkg::fel_entry_t      o_entry,
    output fel_pkg::fel_prio_t       o_mask_boost,
    output fel_pkg::fel_prio_t       o_prog_floor,
    output logic                     o_lockup
);
    import fel_pkg::*;

    if (HAS_SEC != 0 && HAS_SEC != 1) begin : g_chk
        $error("HAS_SEC must be 0 or 1");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Programmable priority on the common scale
    function automatic fel_prio_t map_prio(input logic [7:0] p,
                                           input logic       ns,
                                           input logic       split);
        if (ns && split) begin
            map_prio = fel_prio_t'({2'b00, 1'b1, p[7:1]});
        end else begin
            map_prio = fel_prio_t'({2'b00, p});
        end
    endfunction

    // W1C, set wins
    function automatic logic w1c(input logic q, input logic clr,
                                 input logic set);
        w1c = set | (q & ~clr);
    endfunction

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [3:0]  ctrl_q;
    logic        lock_q;
    logic        nmiblk_q;
    fel_prio_t   lock_prio_q;
    logic [2:1]  uf_q;
    logic [1:0]  mp_seen_q;
    logic [1:0]  mp_val_q;
    logic [1:0]  ue_seen_q;
    logic        be_seen_q;
    logic        be_val_q;
    logic        sv_seen_q;
    logic        sv_val_q;
    logic [31:0] cap0_q;
    logic [31:0] cap1_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    logic bank;
    logic split;
    assign bank  = (HAS_SEC == 1) ? ctrl_q[CTRL_BANK] : 1'b0;
    assign split = (HAS_SEC == 1) ? ctrl_q[CTRL_SPLIT] : 1'b0;

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ----------------------------------------------------------------
    logic req;
    logic wr_go;
    logic rd_go;
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign wr_go             = i_avs_write & ack_q;
    assign rd_go             = i_avs_read & ack_q;

    // Ack on a request's second cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Lane 0 write strobe and clear bits
    logic       wlow;
    logic [7:0] wclr;
    assign wlow = wr_go & i_avs_byteenable[0];
    assign wclr = i_avs_writedata[7:0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a[7:2] == o[7:2]);
    endfunction

    // ----------------------------------------------------------------
    // Target state of this fault
    // ----------------------------------------------------------------
    logic f_sec;
    always_comb begin
        if (HAS_SEC == 0) begin
            f_sec = 1'b0;
        end else if (i_fault.kind == FK_BUSERR) begin
            f_sec = ~bank;
        end else if (i_fault.kind == FK_SECVIOL) begin
            f_sec = 1'b1;
        end else begin
            f_sec = i_fault.secure;
        end
    end

    // ----------------------------------------------------------------
    // Escalation and lockup decision
    // ----------------------------------------------------------------
    fel_prio_t f_prio;
    fel_prio_t hf_prio;
    logic      esc;
    logic      lock;
    logic      shf;
    assign f_prio  = map_prio(i_fault.prio, ~f_sec, split);
    assign shf     = (HAS_SEC == 1) & bank & f_sec;
    assign hf_prio = shf ? PRIO_SHF : PRIO_HF;

    always_comb begin
        esc = 1'b0;
        if (!i_fault.enabled) begin
            esc = 1'b1;
        end
        if (i_exec.in_handler && i_exec.kind == i_fault.kind) begin
            esc = 1'b1;
        end
        if (f_prio >= i_exec.prio) begin
            esc = 1'b1;
        end
        // Corrupt stack still runs its handler
        if (i_fault.kind == FK_BUSERR && i_fault.stack_entry) begin
            esc = 1'b0;
        end
    end

    // Escalated fault that cannot preempt locks up
    assign lock = i_fault.valid & esc & (hf_prio >= i_exec.prio);

    always_comb begin
        o_entry           = '0;
        o_entry.take      = i_fault.valid & ~lock & ~lock_q;
        o_entry.escalate  = i_fault.valid & esc & ~lock;
        o_entry.secure_hf = i_fault.valid & esc & shf;
        o_entry.lock      = lock;
        o_entry.prio      = esc ? hf_prio : f_prio;
    end

    // ----------------------------------------------------------------
    // Mask boosts
    // ----------------------------------------------------------------
    // Boost hits all exceptions, floor programmable only
    always_comb begin
        o_mask_boost = PRIO_IDLE;
        o_prog_floor = PRIO_IDLE;
        if (ctrl_q[CTRL_NMASK]) begin
            if (bank) begin
                o_mask_boost = PRIO_HF;
            end else begin
                o_prog_floor = split ? PRIO_HALF : PRIO_ZERO;
            end
        end
        if (ctrl_q[CTRL_SMASK]) begin
            o_mask_boost = bank ? PRIO_SHF : PRIO_HF;
        end
    end

    // ----------------------------------------------------------------
    // Lockup state
    // ----------------------------------------------------------------
    logic release_ok;
    assign release_ok = i_debug_halt |
                        (i_exc_req & (i_exc_prio < lock_prio_q) &
                         ~(i_exc_is_nmi & nmiblk_q));

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            lock_q      <= 1'b0;
            nmiblk_q    <= 1'b0;
            lock_prio_q <= PRIO_IDLE;
        end else if (lock_q && release_ok) begin
            lock_q      <= 1'b0;
            nmiblk_q    <= 1'b0;
            lock_prio_q <= PRIO_IDLE;
        end else if (!lock_q && lock) begin
            lock_q      <= 1'b1;
            nmiblk_q    <= i_exec.in_nmi | (bank & (i_exec.prio == PRIO_SHF));
            lock_prio_q <= i_exec.prio;
        end
    end
    assign o_lockup = lock_q;

    // ----------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wlow && hit(i_avs_address, OFS_CTRL)) begin
            ctrl_q <= i_avs_writedata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Unrecoverable fault status
    // ----------------------------------------------------------------
    logic uf_clr;
    assign uf_clr = wlow & hit(i_avs_address, OFS_UF_STAT);
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            uf_q <= 2'b00;
        end else begin
            uf_q[UF_ESC]    <= w1c(uf_q[UF_ESC], uf_clr & wclr[UF_ESC],
                                   i_fault.valid & esc);
            uf_q[UF_LOCKUP] <= w1c(uf_q[UF_LOCKUP], uf_clr & wclr[UF_LOCKUP],
                                   lock);
        end
    end

    // ----------------------------------------------------------------
    // Address capture routing
    // ----------------------------------------------------------------
    // Slot 0 secure, slot 1 nonsecure
    logic slot;
    logic want;
    logic busy0;
    logic busy1;
    logic load0;
    logic load1;
    assign slot  = (HAS_SEC == 1) ? ~f_sec : 1'b0;
    assign want  = i_fault.valid & i_fault.addr_ok &
                   (i_fault.kind != FK_USAGE);
    assign busy0 = mp_val_q[0] | sv_val_q | (be_val_q & ~bank);
    assign busy1 = (HAS_SEC == 1) ? (mp_val_q[1] | (be_val_q & bank))
                                  : 1'b0;
    assign load0 = want & ~slot & ~busy0;
    assign load1 = want & slot & ~busy1;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cap0_q <= ZERO_WORD;
        end else if (load0) begin
            cap0_q <= i_fault.addr;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cap1_q <= ZERO_WORD;
        end else if (load1) begin
            cap1_q <= i_fault.addr;
        end
    end

    // ----------------------------------------------------------------
    // Fault status registers
    // ----------------------------------------------------------------
    logic [1:0] mp_hit;
    logic [1:0] ue_hit;
    logic [1:0] mp_clr;
    logic [1:0] ue_clr;
    logic       be_hit;
    logic       sv_hit;
    logic       be_clr;
    logic       sv_clr;
    logic       ld;
    assign ld        = load0 | load1;
    assign mp_hit[0] = i_fault.valid & (i_fault.kind == FK_MEMPROT) & ~slot;
    assign mp_hit[1] = i_fault.valid & (i_fault.kind == FK_MEMPROT) & slot;
    assign ue_hit[0] = i_fault.valid & (i_fault.kind == FK_USAGE) & ~slot;
    assign ue_hit[1] = i_fault.valid & (i_fault.kind == FK_USAGE) & slot;
    assign be_hit    = i_fault.valid & (i_fault.kind == FK_BUSERR);
    assign sv_hit    = i_fault.valid & (i_fault.kind == FK_SECVIOL);
    assign mp_clr[0] = wlow & hit(i_avs_address, OFS_MP_S_STAT);
    assign mp_clr[1] = wlow & hit(i_avs_address, OFS_MP_N_STAT);
    assign ue_clr[0] = wlow & hit(i_avs_address, OFS_UE_S_STAT);
    assign ue_clr[1] = wlow & hit(i_avs_address, OFS_UE_N_STAT);
    assign be_clr    = wlow & hit(i_avs_address, OFS_BE_STAT);
    assign sv_clr    = wlow & hit(i_avs_address, OFS_SV_STAT);

    // Banked copies; copy 0 only without security
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mp_seen_q <= 2'b00;
            mp_val_q  <= 2'b00;
            ue_seen_q <= 2'b00;
        end else begin
            for (int b = 0; b < 2; b++) begin
                mp_seen_q[b] <= w1c(mp_seen_q[b], mp_clr[b] & wclr[FS_SEEN],
                                    mp_hit[b]);
                mp_val_q[b]  <= w1c(mp_val_q[b], mp_clr[b] & wclr[FS_VALID],
                                    mp_hit[b] & ld);
                ue_seen_q[b] <= w1c(ue_seen_q[b], ue_clr[b] & wclr[FS_SEEN],
                                    ue_hit[b]);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            be_seen_q <= 1'b0;
            be_val_q  <= 1'b0;
            sv_seen_q <= 1'b0;
            sv_val_q  <= 1'b0;
        end else begin
            be_seen_q <= w1c(be_seen_q, be_clr & wclr[FS_SEEN], be_hit);
            be_val_q  <= w1c(be_val_q, be_clr & wclr[FS_VALID],
                             be_hit & ld);
            sv_seen_q <= w1c(sv_seen_q, sv_clr & wclr[FS_SEEN], sv_hit);
            sv_val_q  <= w1c(sv_val_q, sv_clr & wclr[SV_VALID],
                             sv_hit & ld);
        end
    end

    // ----------------------------------------------------------------
    // Read data, latched at the acknowledging edge
    // ----------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = ZERO_WORD;
        case (i_avs_address[7:2])
            OFS_CTRL[7:2]:      rmux[3:0]         = ctrl_q;
            OFS_STATE[7:2]: begin
                rmux[ST_LOCK]   = lock_q;
                rmux[ST_NMIBLK] = nmiblk_q;
            end
            OFS_UF_STAT[7:2]:   rmux[UF_LOCKUP:UF_ESC] = uf_q;
            OFS_MP_S_STAT[7:2]: begin
                rmux[FS_SEEN]  = mp_seen_q[0];
                rmux[FS_VALID] = mp_val_q[0];
            end
            OFS_MP_N_STAT[7:2]: begin
                rmux[FS_SEEN]  = mp_seen_q[1];
                rmux[FS_VALID] = mp_val_q[1];
            end
            OFS_BE_STAT[7:2]: begin
                rmux[FS_SEEN]  = be_seen_q;
                rmux[FS_VALID] = be_val_q;
            end
            OFS_SV_STAT[7:2]: begin
                rmux[FS_SEEN]  = sv_seen_q;
                rmux[SV_VALID] = sv_val_q;
            end
            OFS_UE_S_STAT[7:2]: rmux[FS_SEEN] = ue_seen_q[0];
            OFS_UE_N_STAT[7:2]: rmux[FS_SEEN] = ue_seen_q[1];
            OFS_CAP0[7:2]:      rmux = cap0_q;
            OFS_CAP1[7:2]:      rmux = cap1_q;
            default:            rmux = ZERO_WORD;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_q <= ZERO_WORD;
        end else if (i_avs_read && !ack_q) begin
            rdata_q <= rmux;
        end
    end
    assign o_avs_readdata = rd_go ? rdata_q : ZERO_WORD;

endmodule

// ---- test/fel_sva.sv ----
/* Port checker for the fault escalation and lockup block.
   Sees only top-level ports. */
`timescale 1ns/10ps
module fel_sva
    import fel_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire fel_fault_t  i_fault,
    input wire fel_exec_t   i_exec,
    input wire logic        i_exc_req,
    input wire logic        i_debug_halt,
    input wire fel_entry_t  o_entry,
    input wire logic        o_lockup
);
    // ------------------------------------------------------------
    // Port properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Live fault; faults in lockup are refused
    logic live;
    logic bstk;
    assign live = i_fault.valid && !o_lockup;
    assign bstk = (i_fault.kind == FK_BUSERR) && i_fault.stack_entry;
    a_esc_disabled: assert property (live && !i_fault.enabled && !bstk
        |-> o_entry.escalate || o_entry.lock)
        else $error("disabled fault kept");
    a_stack_keep: assert property (live && bstk |-> !o_entry.escalate)
        else $error("push fault escalated");
    a_esc_same: assert property (live && i_exec.in_handler && i_exec.kind == i_fault.kind
        && !bstk |-> o_entry.escalate)
        else $error("same kind kept");
    a_esc_prio: assert property (live && i_fault.kind == FK_MEMPROT && i_fault.secure
        && i_exec.prio <= $signed({2'b00, i_fault.prio}) |-> o_entry.escalate)
        else $error("low fault kept");
    a_no_esc_high: assert property (live && i_fault.enabled && !i_exec.in_handler
        && i_fault.kind == FK_MEMPROT && i_fault.secure
        && i_exec.prio > $signed({2'b00, i_fault.prio}) |-> !o_entry.escalate)
        else $error("high fault escalated");
    a_lock_entry: assert property (live && o_entry.lock |=> o_lockup)
        else $error("no lockup");
    a_lock_refuse: assert property (o_lockup |-> !o_entry.take)
        else $error("taken in lockup");
    a_lock_hold: assert property (o_lockup && !i_exc_req && !i_debug_halt |=> o_lockup)
        else $error("lockup left");
    a_halt_free: assert property (o_lockup && i_debug_halt |=> !o_lockup)
        else $error("halt kept lockup");
    a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("extra wait state");
    a_rdata_quiet: assert property (!(i_avs_read && !o_avs_waitrequest)
        |-> o_avs_readdata == ZERO_WORD)
        else $error("stray read data");
    c_escalate: cover property (live && o_entry.escalate);
    c_lock: cover property (live && o_entry.lock);
    c_leave: cover property ($fell(o_lockup));
endmodule

bind fel_fault_escalation_lockup fel_sva u_sva (
    .i_core_clk, .i_rst_n, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_fault, .i_exec, .i_exc_req, .i_debug_halt,
    .o_entry, .o_lockup
);

// ---- test/fel_pipe_model.sv ----
/* Pipeline-side fault source model.
   Assumes one-cycle fault requests. */
`timescale 1ns/10ps
module fel_pipe_model
    import fel_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_go,
    input  wire fel_fault_t i_req,
    output fel_fault_t      o_fault
);
    // ------------------------------------------------------------
    // Fault pulse
    // ------------------------------------------------------------
    initial o_fault = '0;
    // Payload inverted between faults so stale data never looks live
    always @(posedge i_core_clk) begin
        if (i_go) begin
            o_fault       <= i_req;
            o_fault.valid <= 1'b1;
        end else begin
            o_fault       <= ~o_fault;
            o_fault.valid <= 1'b0;
        end
    end
endmodule

// ---- test/tb_top.sv ----
/* Self-checking bench for the fault escalation block.
   Assumes pipeline model and checker alongside. */
`timescale 1ns/10ps
module tb_top;
    import fel_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    logic        clk, rst_n, rd, wr, go, exc_req, exc_nmi, halt, wait_r, lock;
    logic [7:0]  addr;
    logic [31:0] wdata, rdout, rdata, a, b, s;
    fel_prio_t   exc_prio, boost, floor_p;
    fel_fault_t  freq, fault, f;
    fel_exec_t   exec;
    fel_entry_t  entry;
    int          fail_count, total_checks, seed;
    logic [7:0]  offs [6] = '{OFS_CTRL, OFS_STATE, OFS_UF_STAT, OFS_CAP0, OFS_CAP1, 8'h3C};

    fel_fault_escalation_lockup dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdout), .o_avs_waitrequest(wait_r), .i_fault(fault), .i_exec(exec),
        .i_exc_req(exc_req), .i_exc_is_nmi(exc_nmi), .i_exc_prio(exc_prio),
        .i_debug_halt(halt), .o_entry(entry), .o_mask_boost(boost), .o_prog_floor(floor_p),
        .o_lockup(lock));
    fel_pipe_model pipe_u (.i_core_clk(clk), .i_go(go), .i_req(freq), .o_fault(fault));

    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Avalon access, held until waitrequest low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= ad;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 20);
        rdata = rdout;
        if (n >= 20) fail_count++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Fault pulse; returns while o_entry shows it
    task automatic hit(input fel_fault_t ff);
        @(posedge clk);
        go <= 1'b1;
        freq <= ff;
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask
    task automatic rel(input logic nmi, input logic dbg, input fel_prio_t p);
        @(posedge clk);
        exc_req <= !dbg;
        exc_nmi <= nmi;
        exc_prio <= p;
        halt <= dbg;
        @(posedge clk);
        exc_req <= 1'b0;
        halt <= 1'b0;
        #1;
    endtask
    function automatic fel_fault_t mk(fel_kind_t k, logic sc, logic [7:0] p, logic en,
                                      logic [31:0] ad);
        mk = '{1'b1, k, sc, p, en, 1'b0, 1'b1, ad};
    endfunction
    function automatic fel_prio_t exp_boost(logic [3:0] c);
        if (c[2]) return c[0] ? PRIO_SHF : PRIO_HF;
        return (c[3] && c[0]) ? PRIO_HF : PRIO_IDLE;
    endfunction
    function automatic fel_prio_t exp_floor(logic [3:0] c);
        if (c[3] && !c[0]) return c[1] ? PRIO_HALF : PRIO_ZERO;
        return PRIO_IDLE;
    endfunction
    // Nonsecure priorities fold into the lower half when split
    function automatic logic exp_esc(int p, logic nssplit, int e);
        return (nssplit ? 128 + p / 2 : p) >= e;
    endfunction
    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog, about 13x the expected run
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        {clk, rst_n, rd, wr, go, exc_req, exc_nmi, halt} = '0;
        {addr, wdata, exc_prio, freq} = '0;
        exec = '0;
        fail_count = 0;
        total_checks = 0;
        seed = 32'h07f07f63;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (offs[i]) begin
            bus(0, offs[i], 0);
            chk(rdata, ZERO_WORD);
        end
        for (int c = 0; c < 16; c++) begin
            bus(1, OFS_CTRL, c);
            bus(0, OFS_CTRL, 0);
            chk(rdata, c);
            chk(32'(boost), 32'(exp_boost(c[3:0])));
            chk(32'(floor_p), 32'(exp_floor(c[3:0])));
        end
        bus(1, OFS_CTRL, 0);
        exec <= '{1'b0, FK_USAGE, 1'b0, PRIO_IDLE};
        a = $random(seed);
        b = $random(seed);
        hit(mk(FK_MEMPROT, 1, 8'h10, 1, a));
        hit(mk(FK_MEMPROT, 1, 8'h10, 1, b));
        bus(0, OFS_CAP0, 0);
        chk(rdata, a);
        bus(0, OFS_MP_S_STAT, 0);
        chk(rdata, 32'h81);
        bus(1, OFS_MP_S_STAT, 32'h80);
        hit(mk(FK_MEMPROT, 1, 8'h10, 1, b));
        bus(0, OFS_CAP0, 0);
        chk(rdata, b);
        hit(mk(FK_MEMPROT, 0, 8'h10, 1, a));
        bus(0, OFS_CAP1, 0);
        chk(rdata, a);
        bus(0, OFS_MP_N_STAT, 0);
        chk(rdata, 32'h81);
        // Equal-priority corners, then random
        for (int i = 0; i < 24; i++) begin
            s = (i == 0) ? 32'h0001_0140 : (i == 1) ? 32'h0000_0280 : $random(seed);
            bus(1, OFS_CTRL, {30'h0, s[9], 1'b0});
            exec <= '{1'b0, FK_MEMPROT, 1'b0, fel_prio_t'({2'b00, s[7:0]})};
            hit(mk(FK_MEMPROT, s[8], s[17:10], 1, s));
            chk(32'(entry.escalate), 32'(exp_esc(s[17:10], !s[8] && s[9], s[7:0])));
        end
        exec <= '{1'b1, FK_BUSERR, 1'b0, 10'sd255};
        f = mk(FK_BUSERR, 1, 0, 1, a);
        f.stack_entry = 1'b1;
        hit(f);
        chk(32'(entry.escalate), 0);
        hit(mk(FK_BUSERR, 1, 0, 1, a));
        chk(32'(entry.escalate), 1);
        hit(mk(FK_USAGE, 1, 0, 0, a));
        chk(32'(entry.escalate), 1);
        bus(0, OFS_UF_STAT, 0);
        chk(rdata, 32'h02);
        exec <= '{1'b1, FK_MEMPROT, 1'b0, PRIO_HF};
        hit(mk(FK_USAGE, 1, 0, 0, a));
        chk(32'(entry.lock), 1);
        hit(mk(FK_USAGE, 1, 0, 0, a));
        chk(32'(entry.take), 0);
        rel(0, 0, PRIO_HF);
        chk(32'(lock), 1);
        rel(1, 0, PRIO_NMI);
        chk(32'(lock), 0);
        exec <= '{1'b0, FK_USAGE, 1'b1, PRIO_NMI};
        hit(mk(FK_USAGE, 1, 0, 0, a));
        bus(0, OFS_STATE, 0);
        chk(rdata, 32'h3);
        rel(1, 0, PRIO_SHF);
        chk(32'(lock), 1);
        rel(0, 1, PRIO_IDLE);
        chk(32'(lock), 0);
        hit(mk(FK_USAGE, 1, 0, 0, a));
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(32'(lock), 0);
        end_of_test();
    end
endmodule
